/* File: adc_output_end.sv */
// Purpose: digital output end of a 12-bit sampling converter
// Assumes: encode clock, level and strap arrive asynchronously
// Notes:   forwarded clock is rebuilt on sys_clk from encode edges
`timescale 1ns/1ps
module adc_output_end #(
  parameter int STALL_CYCLES = adc_out_pkg::DCS_STALL_CYCLES,
  parameter int RELOCK_EDGES = adc_out_pkg::DCS_RELOCK_EDGES
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   encode_clock_pos,
  input  wire logic signed [adc_out_pkg::LEVEL_W-1:0] analog_level,
  input  wire logic [1:0]                             mode_strap,
  output logic                                        dcs_locked,
  output logic                                        twos_format,
  adc_link_if.dev                                     link
);
  localparam int SYNC_W = adc_out_pkg::LEVEL_W + 3;
  localparam logic [adc_out_pkg::CNT_W-1:0] STALL_C =
    adc_out_pkg::CNT_W'(STALL_CYCLES);
  localparam logic [7:0] RELOCK_C = 8'(RELOCK_EDGES);
  localparam logic [1:0] SETTLE_C = 2'(adc_out_pkg::STRAP_SETTLE);

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0]                      sync_q;
  logic                                   enc_s;
  logic signed [adc_out_pkg::LEVEL_W-1:0] level_s;
  logic [1:0]                             strap_s;

  sync2 #(.W(SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({encode_clock_pos, analog_level, mode_strap}),
    .q       (sync_q)
  );
  assign enc_s   = sync_q[SYNC_W-1];
  assign level_s = sync_q[SYNC_W-2:2];
  assign strap_s = sync_q[1:0];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                           enc_d_r, enc_d_nxt;
  logic [1:0]                     settle_r, settle_nxt;
  logic                           twos_r, twos_nxt;
  logic                           dcs_on_r, dcs_on_nxt;
  logic [adc_out_pkg::CNT_W-1:0]  since_r, since_nxt;
  logic [adc_out_pkg::CNT_W-1:0]  period_r, period_nxt;
  logic                           locked_r, locked_nxt;
  logic [7:0]                     edges_r, edges_nxt;
  logic                           fclk_r, fclk_nxt;
  logic [adc_out_pkg::WORD_W-1:0] word_r, word_nxt;
  logic                           over_r, over_nxt;
  logic                           oe_r, oe_nxt;
  logic                           dcs_lk_r, dcs_lk_nxt;
  adc_out_pkg::power_state_t      pwr;
  logic                           rise, fall;
  logic [adc_out_pkg::WORD_W-1:0] code;
  logic                           over;

  assign rise = enc_s & ~enc_d_r;
  assign fall = ~enc_s & enc_d_r;

  // power state follows shutdown and enable directly
  always_comb begin
    if (!link.power_down_select) begin
      pwr = adc_out_pkg::PWR_NORMAL;
    end else if (link.output_enable_n) begin
      pwr = adc_out_pkg::PWR_SLEEP;
    end else begin
      pwr = adc_out_pkg::PWR_NAP;
    end
  end

  // sample coding; offset binary is two's complement with msb flipped
  always_comb begin
    over = 1'b0;
    code = level_s[adc_out_pkg::WORD_W-1:0];
    if (level_s > adc_out_pkg::LEVEL_MAX) begin
      over = 1'b1;
      code = adc_out_pkg::TC_TOP;
    end else if (level_s < adc_out_pkg::LEVEL_MIN) begin
      over = 1'b1;
      code = adc_out_pkg::TC_BOTTOM;
    end
    if (!twos_r) begin
      code = code ^ adc_out_pkg::MSB_FLIP;
    end
  end

  // strap capture once the synchroniser has filled after reset
  always_comb begin
    settle_nxt = settle_r;
    twos_nxt   = twos_r;
    dcs_on_nxt = dcs_on_r;
    if (settle_r != SETTLE_C) begin
      settle_nxt = settle_r + 2'd1;
      if (settle_nxt == SETTLE_C) begin
        case (adc_out_pkg::strap_level_t'(strap_s))
          adc_out_pkg::STRAP_GND: begin
            twos_nxt   = 1'b0;
            dcs_on_nxt = 1'b0;
          end
          adc_out_pkg::STRAP_THIRD: begin
            twos_nxt   = 1'b0;
            dcs_on_nxt = 1'b1;
          end
          adc_out_pkg::STRAP_TWO_THIRDS: begin
            twos_nxt   = 1'b1;
            dcs_on_nxt = 1'b1;
          end
          default: begin
            twos_nxt   = 1'b1;
            dcs_on_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // encode period measure and stabilizer lock
  always_comb begin
    since_nxt  = since_r;
    period_nxt = period_r;
    locked_nxt = locked_r;
    edges_nxt  = edges_r;
    if (rise) begin
      since_nxt  = '0;
      period_nxt = since_r + adc_out_pkg::CNT_W'(1);
      if (!locked_r) begin
        edges_nxt = edges_r + 8'd1;
        if (edges_nxt == RELOCK_C) begin
          locked_nxt = 1'b1;
        end
      end
    end else if (since_r != STALL_C) begin
      since_nxt = since_r + adc_out_pkg::CNT_W'(1);
    end
    // a stopped clock or sleep loses lock and restarts the edge count
    if ((since_r == STALL_C) || (pwr == adc_out_pkg::PWR_SLEEP)) begin
      locked_nxt = 1'b0;
      edges_nxt  = '0;
    end
    // status pin is registered so it comes from a flop, not a gate
    dcs_lk_nxt = locked_nxt & dcs_on_nxt;
  end

  // forwarded clock, word and flag; data moves with the clock rise
  always_comb begin
    enc_d_nxt = enc_s;
    fclk_nxt  = fclk_r;
    word_nxt  = word_r;
    over_nxt  = over_r;
    oe_nxt    = (pwr == adc_out_pkg::PWR_NORMAL) &
                ~link.output_enable_n;
    if (pwr == adc_out_pkg::PWR_NORMAL) begin
      if (rise) begin
        fclk_nxt = 1'b1;
        word_nxt = code;
        over_nxt = over;
      end else if (dcs_on_r && locked_r) begin
        // internal fall at half the measured period
        if (since_r == (period_r >> 1)) begin
          fclk_nxt = 1'b0;
        end
      end else if (fall) begin
        fclk_nxt = 1'b0;
      end
    end else begin
      fclk_nxt = 1'b0;
    end
  end

  // register every group
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_d_r  <= 1'b0;
      settle_r <= '0;
      twos_r   <= 1'b0;
      dcs_on_r <= 1'b0;
      since_r  <= '0;
      period_r <= '0;
      locked_r <= 1'b0;
      edges_r  <= '0;
      fclk_r   <= 1'b0;
      word_r   <= '0;
      over_r   <= 1'b0;
      oe_r     <= 1'b0;
      dcs_lk_r <= 1'b0;
    end else begin
      enc_d_r  <= enc_d_nxt;
      settle_r <= settle_nxt;
      twos_r   <= twos_nxt;
      dcs_on_r <= dcs_on_nxt;
      since_r  <= since_nxt;
      period_r <= period_nxt;
      locked_r <= locked_nxt;
      edges_r  <= edges_nxt;
      fclk_r   <= fclk_nxt;
      word_r   <= word_nxt;
      over_r   <= over_nxt;
      oe_r     <= oe_nxt;
      dcs_lk_r <= dcs_lk_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign link.forwarded_sample_clock = fclk_r;
  assign link.sample_word            = word_r;
  assign link.overrange_flag         = over_r;
  assign link.pins_oe                = oe_r;
  assign twos_format                 = twos_r;
  assign dcs_locked                  = dcs_lk_r;
endmodule

/* File: adc_out_pkg.sv */
// Purpose: shared constants for the converter output link and its receiver
// Assumes: one system clock at SYS_CLK_MHZ
// Notes:   strap and power states are enumerated here
package adc_out_pkg;
  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_MHZ       = 200;
  localparam int DCS_STALL_NS      = 1000;  // encode gap that drops lock
  localparam int DCS_STALL_CYCLES  = (DCS_STALL_NS * SYS_CLK_MHZ) / 1000;
  localparam int DCS_RELOCK_EDGES  = 100;
  localparam int NAP_DISCARD_EDGES = 100;
  localparam int OE_HOLD_NS        = 1000;  // least spacing of oe changes
  localparam int OE_HOLD_CYCLES    = (OE_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SLEEP_WAKE_US     = 2000;  // reference settling wait
  localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_US * SYS_CLK_MHZ;
  localparam int STRAP_SETTLE      = 3;
  localparam int CNT_W             = 16;

  // ----------------------------------------------------------------------
  // sample coding
  // ----------------------------------------------------------------------
  localparam int WORD_W  = 12;
  localparam int LEVEL_W = 14;
  localparam logic signed [LEVEL_W-1:0] LEVEL_MAX = 14'sh07ff;
  localparam logic signed [LEVEL_W-1:0] LEVEL_MIN = 14'sh3800;
  localparam logic [WORD_W-1:0] OB_TOP    = 12'hfff;
  localparam logic [WORD_W-1:0] OB_BOTTOM = 12'h000;
  localparam logic [WORD_W-1:0] TC_TOP    = 12'h7ff;
  localparam logic [WORD_W-1:0] TC_BOTTOM = 12'h800;
  localparam logic [WORD_W-1:0] MSB_FLIP  = 12'h800;

  typedef enum logic [1:0] {
    STRAP_GND, STRAP_THIRD, STRAP_TWO_THIRDS, STRAP_SUPPLY
  } strap_level_t;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_NAP, PWR_SLEEP} power_state_t;
  typedef enum logic [1:0] {
    WK_READY, WK_DOWN, WK_SLEEP_WAIT, WK_NAP_WAIT
  } wake_state_t;

  // ----------------------------------------------------------------------
  // receiver registers
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SAMPLE = 8'h0c;
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam int CTRL_PWRDN_BIT  = 1;
  localparam int EV_W            = 3;
  localparam int EV_SAMPLE_BIT   = 0;
  localparam int EV_OVER_BIT     = 1;
  localparam int EV_VALID_BIT    = 2;
  localparam int SAMPLE_OVER_BIT  = 12;
  localparam int SAMPLE_VALID_BIT = 13;
endpackage

/* File: adc_link_if.sv */
// Purpose: pins between converter output end and capturing receiver
// Assumes: both ends on sys_clk; pins cross as asynchronous levels
// Notes:   pins_oe high while the converter drives its outputs
`timescale 1ns/1ps
interface adc_link_if;
  logic [adc_out_pkg::WORD_W-1:0] sample_word;
  logic                           overrange_flag;
  logic                           forwarded_sample_clock;
  logic                           pins_oe;
  logic                           output_enable_n;
  logic                           power_down_select;

  modport dev (
    output sample_word,
    output overrange_flag,
    output forwarded_sample_clock,
    output pins_oe,
    input  output_enable_n,
    input  power_down_select
  );
  modport rcv (
    input  sample_word,
    input  overrange_flag,
    input  forwarded_sample_clock,
    input  pins_oe,
    output output_enable_n,
    output power_down_select
  );
endinterface

/* File: sync2.sv */
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: bits are static or independent enough to cross as levels
// Notes:   first stage feeds the second and nothing else
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two flops in series, reset to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: adc_capture_end.sv */
// Purpose: receiver that captures converter samples and controls power
// Assumes: link pins asynchronous to sys_clk, sampled by two flops
// Notes:   samples are taken on the forwarded clock falling edge
`timescale 1ns/1ps
module adc_capture_end #(
  parameter int SLEEP_WAKE = adc_out_pkg::SLEEP_WAKE_CYCLES,
  parameter int OE_HOLD    = adc_out_pkg::OE_HOLD_CYCLES,
  parameter int NAP_EDGES  = adc_out_pkg::NAP_DISCARD_EDGES
) (
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire logic [adc_out_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [adc_out_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [adc_out_pkg::DATA_W-1:0]   reg_rdata,
  output logic                                  irq,
  output logic      [adc_out_pkg::WORD_W-1:0]   sample_out,
  output logic                                  sample_over,
  output logic                                  sample_strobe,
  adc_link_if.rcv                               link
);
  // one counter width must hold the longest of the three waits
  localparam int WAIT_W = $clog2(SLEEP_WAKE + OE_HOLD + NAP_EDGES + 1) + 1;
  localparam logic [WAIT_W-1:0] SLEEP_C = WAIT_W'(SLEEP_WAKE);
  localparam logic [WAIT_W-1:0] OE_C    = WAIT_W'(OE_HOLD);
  localparam logic [WAIT_W-1:0] NAP_C   = WAIT_W'(NAP_EDGES);
  localparam int SW = adc_out_pkg::WORD_W + 3;
  localparam int EW = adc_out_pkg::EV_W;

  // ----------------------------------------------------------------------
  // link synchronisation and falling edge detect
  // ----------------------------------------------------------------------
  logic [SW-1:0] sync_q;
  logic          fclk_s, over_s, oe_s, fclk_d_r, fall;

  sync2 #(.W(SW)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({link.forwarded_sample_clock, link.overrange_flag,
               link.pins_oe, link.sample_word}),
    .q       (sync_q)
  );
  assign fclk_s = sync_q[SW-1];
  assign over_s = sync_q[SW-2];
  assign oe_s   = sync_q[SW-3];
  assign fall   = ~fclk_s & fclk_d_r & oe_s;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [1:0]                     ctrl_r, ctrl_nxt;
  logic [EW-1:0]                  status_r, status_nxt, mask_r, mask_nxt;
  logic [adc_out_pkg::DATA_W-1:0] rdata_nxt;
  logic                           irq_nxt;
  logic                           oe_n_r, oe_n_nxt, pd_r, pd_nxt;
  logic [WAIT_W-1:0]              hold_r, hold_nxt, wait_r, wait_nxt;
  adc_out_pkg::wake_state_t       wk_r, wk_nxt;
  logic                           slept_r, slept_nxt;
  logic [adc_out_pkg::WORD_W-1:0] word_r, word_nxt;
  logic                           over_r, over_nxt, strobe_nxt;
  logic                           valid;
  logic [EW-1:0]                  ev;

  assign valid = (wk_r == adc_out_pkg::WK_READY) & oe_s;

  // enable changes are spaced; a quick request is deferred, not lost
  always_comb begin
    oe_n_nxt = oe_n_r;
    pd_nxt   = ctrl_r[adc_out_pkg::CTRL_PWRDN_BIT];
    hold_nxt = hold_r;
    if (hold_r != '0) begin
      hold_nxt = hold_r - WAIT_W'(1);
    end else if (oe_n_r == ctrl_r[adc_out_pkg::CTRL_OUT_EN_BIT]) begin
      oe_n_nxt = ~ctrl_r[adc_out_pkg::CTRL_OUT_EN_BIT];
      hold_nxt = OE_C;
    end
  end

  // wake tracking: sleep waits for the reference, nap discards edges
  always_comb begin
    wk_nxt   = wk_r;
    wait_nxt = wait_r;
    // enable may move in the release cycle, so keep the mode seen while down
    slept_nxt = pd_r ? oe_n_r : slept_r;
    case (wk_r)
      adc_out_pkg::WK_DOWN: begin
        if (!pd_r) begin
          wait_nxt = '0;
          wk_nxt   = slept_r ? adc_out_pkg::WK_SLEEP_WAIT
                             : adc_out_pkg::WK_NAP_WAIT;
        end
      end
      adc_out_pkg::WK_SLEEP_WAIT: begin
        wait_nxt = wait_r + WAIT_W'(1);
        if (wait_nxt == SLEEP_C) begin
          wk_nxt = adc_out_pkg::WK_READY;
        end
      end
      adc_out_pkg::WK_NAP_WAIT: begin
        if (fall) begin
          wait_nxt = wait_r + WAIT_W'(1);
          if (wait_nxt == NAP_C) begin
            wk_nxt = adc_out_pkg::WK_READY;
          end
        end
      end
      default: begin
        wait_nxt = '0;
      end
    endcase
    if (pd_r) begin
      wk_nxt = adc_out_pkg::WK_DOWN;
    end
  end

  // capture word and flag together on the falling edge
  always_comb begin
    word_nxt   = word_r;
    over_nxt   = over_r;
    strobe_nxt = 1'b0;
    if (fall && valid) begin
      word_nxt   = sync_q[adc_out_pkg::WORD_W-1:0];
      over_nxt   = over_s;
      strobe_nxt = 1'b1;
    end
  end

  // registers; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[adc_out_pkg::EV_SAMPLE_BIT] = strobe_nxt;
    ev[adc_out_pkg::EV_OVER_BIT]   = strobe_nxt & over_nxt;
    ev[adc_out_pkg::EV_VALID_BIT]  = (wk_nxt == adc_out_pkg::WK_READY) &
                                     (wk_r != adc_out_pkg::WK_READY);
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    rdata_nxt  = '0;
    if (reg_wr && reg_addr == adc_out_pkg::REG_CTRL) begin
      ctrl_nxt = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == adc_out_pkg::REG_MASK) begin
      mask_nxt = reg_wdata[EW-1:0];
    end
    if (reg_wr && reg_addr == adc_out_pkg::REG_STATUS) begin
      status_nxt = status_r & ~reg_wdata[EW-1:0];
    end
    status_nxt = status_nxt | ev;
    if (reg_rd) begin
      case (reg_addr)
        adc_out_pkg::REG_CTRL:   rdata_nxt[1:0] = ctrl_r;
        adc_out_pkg::REG_STATUS: rdata_nxt[EW-1:0] = status_r;
        adc_out_pkg::REG_MASK:   rdata_nxt[EW-1:0] = mask_r;
        adc_out_pkg::REG_SAMPLE: begin
          rdata_nxt[adc_out_pkg::WORD_W-1:0]       = word_r;
          rdata_nxt[adc_out_pkg::SAMPLE_OVER_BIT]  = over_r;
          rdata_nxt[adc_out_pkg::SAMPLE_VALID_BIT] = valid;
        end
        default: rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // register every group
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fclk_d_r      <= 1'b0;
      ctrl_r        <= '0;
      status_r      <= '0;
      mask_r        <= '0;
      reg_rdata     <= '0;
      irq           <= 1'b0;
      oe_n_r        <= 1'b1;
      pd_r          <= 1'b0;
      hold_r        <= '0;
      wait_r        <= '0;
      wk_r          <= adc_out_pkg::WK_READY;
      slept_r       <= 1'b0;
      word_r        <= '0;
      over_r        <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      fclk_d_r      <= fclk_s;
      ctrl_r        <= ctrl_nxt;
      status_r      <= status_nxt;
      mask_r        <= mask_nxt;
      reg_rdata     <= rdata_nxt;
      irq           <= irq_nxt;
      oe_n_r        <= oe_n_nxt;
      pd_r          <= pd_nxt;
      hold_r        <= hold_nxt;
      wait_r        <= wait_nxt;
      wk_r          <= wk_nxt;
      slept_r       <= slept_nxt;
      word_r        <= word_nxt;
      over_r        <= over_nxt;
      sample_strobe <= strobe_nxt;
    end
  end

  assign sample_out             = word_r;
  assign sample_over            = over_r;
  assign link.output_enable_n   = oe_n_r;
  assign link.power_down_select = pd_r;
endmodule

/* File: adc_link_chk.sv */
// Purpose: pin checks on the link between converter and receiver
// Assumes: one sys_clk domain, rst_n async active low
// Notes:   watches the converter end's pins and the receiver's enable and power down
`timescale 1ns/1ps
module adc_link_chk (
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  input wire logic [adc_out_pkg::WORD_W-1:0] sample_word,
  input wire logic                           overrange_flag,
  input wire logic                           forwarded_sample_clock,
  input wire logic                           pins_oe,
  input wire logic                           output_enable_n,
  input wire logic                           power_down_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------
  a_oe_gates_pins: assert property (output_enable_n |=> !pins_oe)
    else $error("pins driven while disabled");
  a_pd_gates_pins: assert property (power_down_select |=> !pins_oe)
    else $error("pins driven in power down");
  a_pins_enable: assert property (
    !output_enable_n && !power_down_select |=> pins_oe)
    else $error("pins not driven in normal mode");
  a_pd_clock_low: assert property (
    power_down_select [*4] |-> !forwarded_sample_clock)
    else $error("forwarded clock runs in power down");
  a_pd_no_update: assert property (
    power_down_select [*4] |-> $stable(sample_word))
    else $error("word updates in power down");
  // ----------------------------------------------------------------
  // data timing and coding
  // ----------------------------------------------------------------
  a_word_at_rise: assert property (
    $changed(sample_word) |-> $rose(forwarded_sample_clock))
    else $error("word changed off the clock rise");
  a_flag_with_word: assert property (
    $changed(overrange_flag) |-> $rose(forwarded_sample_clock))
    else $error("flag changed off the clock rise");
  a_clip_codes: assert property (overrange_flag |->
    sample_word inside {12'hfff, 12'h000, 12'h7ff, 12'h800})
    else $error("flag set on an unclipped word");
  // encode period is 32 cycles, so rises can never be this close
  a_rise_spacing: assert property (
    $rose(forwarded_sample_clock) |=> !$rose(forwarded_sample_clock) [*8])
    else $error("forwarded clock rises too fast");
endmodule

/* File: testbench.sv */
// Purpose: both ends joined, driven through the receiver registers
// Assumes: encode clock free running at 160 ns
// Notes:   small wake and hold counts keep the run short
`timescale 1ns/1ps
module testbench;
  logic               sys_clk, rst_n, enc, wr, rd, irq, strobe, over;
  logic               lock, twos;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic [11:0]        sout;
  logic [1:0]         strap;
  logic signed [13:0] lvl;
  logic signed [13:0] lv [6] = '{2048, -2049, 5, -5, 2047, -2048};
  int                 failures, n_checks, n;
  adc_link_if link ();
  adc_output_end #(.STALL_CYCLES(64)) u_adc_output_end (.sys_clk(sys_clk),
    .rst_n(rst_n), .encode_clock_pos(enc), .analog_level(lvl),
    .mode_strap(strap), .dcs_locked(lock), .twos_format(twos), .link(link));
  adc_capture_end #(.SLEEP_WAKE(50), .OE_HOLD(4)) u_adc_capture_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq),
    .sample_out(sout), .sample_over(over), .sample_strobe(strobe),
    .link(link));
  adc_link_chk u_adc_link_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .sample_word(link.sample_word), .overrange_flag(link.overrange_flag),
    .forwarded_sample_clock(link.forwarded_sample_clock),
    .pins_oe(link.pins_oe), .output_enable_n(link.output_enable_n),
    .power_down_select(link.power_down_select));
  // ----------------------------------------------------------------
  // clocks: encode phase unrelated to sys_clk
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    enc = 0;
    #3;
    forever #80 enc = ~enc;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [7:0] a, logic [31:0] exp);
    addr <= a;
    rd <= 1;
    @(posedge sys_clk);
    rd <= 0;
    #1 chk("rdata", rdata, exp);
    @(posedge sys_clk);
  endtask
  // cycles from call to next strobe, bounded so a hang ends the run
  task automatic wait_strobe();
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 6000) begin
        failures++;
        finish_test();
      end
    end while (strobe !== 1'b1);
    @(posedge sys_clk);
  endtask
  // clip first in two's complement, offset binary flips the msb
  function automatic logic [12:0] code(logic signed [13:0] v, logic tc);
    logic [11:0] w;
    w = (v > 2047) ? 12'h7ff : (v < -2048) ? 12'h800 : v[11:0];
    return {(v > 2047) || (v < -2048), tc ? w : w ^ 12'h800};
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, addr, wdata, lvl, strap, failures, n_checks} = '0;
    for (int s = 0; s < 4; s++) begin
      rst_n <= 0;
      strap <= s[1:0];
      repeat (10) @(posedge sys_clk);
      rst_n <= 1;
      repeat (6) @(posedge sys_clk);
      chk("twos", twos, s > 1);
      chk("oe off", link.pins_oe, 0);
      wreg(adc_out_pkg::REG_CTRL, 1);
      foreach (lv[i]) begin
        lvl <= lv[i];
        wait_strobe();
        wait_strobe();
        chk("code", {over, sout}, code(lv[i], s > 1));
      end
      repeat (3600) @(posedge sys_clk);
      chk("lock", lock, s == 1 || s == 2);
    end
    chk("irq", irq, 0);
    wreg(adc_out_pkg::REG_MASK, 2);
    #1 chk("irq", irq, 1);
    wreg(adc_out_pkg::REG_STATUS, 2);
    rreg(adc_out_pkg::REG_SAMPLE, 32'h0000_2800);
    chk("irq", irq, 0);
    rreg(8'h40, 0);
    wreg(adc_out_pkg::REG_CTRL, 2);
    repeat (20) @(posedge sys_clk);
    chk("sleep", {link.pins_oe, link.forwarded_sample_clock}, 0);
    wreg(adc_out_pkg::REG_CTRL, 1);
    wait_strobe();
    chk("sleep wait", n >= 50 && n < 100, 1);
    wreg(adc_out_pkg::REG_CTRL, 3);
    repeat (20) @(posedge sys_clk);
    chk("nap", link.pins_oe, 0);
    wreg(adc_out_pkg::REG_STATUS, 7);
    @(posedge sys_clk);
    wreg(adc_out_pkg::REG_CTRL, 1);
    wait_strobe();
    chk("nap wait", n > 3150, 1);
    rreg(adc_out_pkg::REG_STATUS, 5);
    finish_test();
  end
endmodule
